// *** logic/rioc_core.sv ***
// Residual instantaneous overcurrent decision core with trip gating
// What this block does
// - A mode input selects off, peak value or fundamental RMS; it is not registered and has no reset value.
// - The internal trip asserts on the clock edge after a valid strobe whose selected current exceeds the threshold.
// - The start threshold is an integer percent setting of 1 % steps, resetting to 200.
// - Accepted settings run from a configurable low limit to 1000, or 3000 with option.
// - While the double input is high the threshold used is twice the setting.
// - While the disable input is high the general trip is low from the next clock edge on.
// - The general trip is the internal trip gated by disable low and a mode other than off.
// - The internal trip is a level held between strobes, cleared by a strobe at or below threshold or by mode off.
`default_nettype none
module rioc_core #(
  parameter logic [11:0] MIN_PCT = rioc_pkg::START_PCT_MIN
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire rioc_pkg::rioc_meas_t meas_i,
  input wire rioc_pkg::rioc_mode_t mode_i,
  input wire logic [rioc_pkg::PCT_W-1:0] start_pct_i,
  input wire logic start_pct_load_i,
  input wire logic ext_range_i,
  input wire logic threshold_double_in_i,
  input wire logic function_disable_in_i,
  input wire logic [rioc_pkg::CUR_W-1:0] rated_current_i,
  output logic internal_trip_o,
  output logic general_trip_out_o,
  output logic [rioc_pkg::PCT_W-1:0] start_pct_o
);
  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Low limit must be non-zero and leave a usable setting range
  if (MIN_PCT == 12'h000 || MIN_PCT > rioc_pkg::START_PCT_MAX) begin : g_chk
    $error("MIN_PCT out of range");
  end
  // Helper functions below are sized for these package widths only
  if (rioc_pkg::CUR_W != 16 || rioc_pkg::PCT_W != 12) begin : g_chk_w
    $error("current or setting width not served by the helpers");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Current threshold scaled by 100: rated * pct, doubled when dbl is set
  function automatic logic [31:0] thr_amps(input logic [15:0] rated,
                                           input logic [11:0] pct,
                                           input logic dbl);
    logic [31:0] prod;
    prod = 32'(rated) * 32'(pct);
    if (dbl) begin
      prod = prod << 1;
    end
    return prod;
  endfunction : thr_amps

  // Setting accepted when inside the active range
  function automatic logic pct_ok(input logic [11:0] pct, input logic ext);
    logic [11:0] hi;
    hi = ext ? rioc_pkg::START_PCT_MAX_EXT : rioc_pkg::START_PCT_MAX;
    return (pct >= MIN_PCT) && (pct <= hi);
  endfunction : pct_ok

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rioc_pkg::rioc_state_t st_ff;
  rioc_pkg::rioc_state_t nxt_st;
  logic [rioc_pkg::CUR_W-1:0] sel_cur;
  logic above;

  // Quantity selection by mode
  // Unused code 3 compares zero, so a strobe then clears the trip
  always_comb begin
    unique case (mode_i)
      rioc_pkg::RIOC_MODE_PEAK: sel_cur = meas_i.peak;
      rioc_pkg::RIOC_MODE_FUND: sel_cur = meas_i.fund;
      default: sel_cur = '0;
    endcase
  end

  // Compare current*100 against rated*pct (scaled thresholds, no delay)
  assign above = (32'(sel_cur) * 32'(rioc_pkg::PCT_DIV)) >
                 thr_amps(rated_current_i, st_ff.start_pct, threshold_double_in_i);

  // Next state
  always_comb begin
    nxt_st = st_ff;
    if (start_pct_load_i && pct_ok(start_pct_i, ext_range_i)) begin
      nxt_st.start_pct = start_pct_i;
    end
    if (mode_i == rioc_pkg::RIOC_MODE_OFF) begin
      nxt_st.internal_trip = 1'b0;
    end else if (meas_i.valid) begin
      nxt_st.internal_trip = above;
    end
    // General trip gated by disable and mode, one edge after the cause
    nxt_st.general_trip = nxt_st.internal_trip && !function_disable_in_i
                          && (mode_i != rioc_pkg::RIOC_MODE_OFF);
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_ff <= '{internal_trip: 1'b0, general_trip: 1'b0,
                 start_pct: rioc_pkg::START_PCT_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign internal_trip_o = st_ff.internal_trip;
  assign general_trip_out_o = st_ff.general_trip;
  assign start_pct_o = st_ff.start_pct;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_trip_on_strobe;
    @(posedge clock_i) disable iff (sys_rst_i)
      meas_i.valid && mode_i != rioc_pkg::RIOC_MODE_OFF |=> internal_trip_o == $past(above);
  endproperty
  a_trip_on_strobe: assert property (p_trip_on_strobe)
    else $error("trip not per compare");

  property p_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      !meas_i.valid && mode_i != rioc_pkg::RIOC_MODE_OFF |=> $stable(internal_trip_o);
  endproperty
  a_hold: assert property (p_hold) else $error("trip changed without strobe");

  property p_block;
    @(posedge clock_i) disable iff (sys_rst_i)
      function_disable_in_i |=> !general_trip_out_o;
  endproperty
  a_block: assert property (p_block) else $error("trip while disabled");

  property p_off;
    @(posedge clock_i) disable iff (sys_rst_i)
      mode_i == rioc_pkg::RIOC_MODE_OFF |=> !general_trip_out_o && !internal_trip_o;
  endproperty
  a_off: assert property (p_off) else $error("trip while off");

  property p_gen_follows;
    @(posedge clock_i) disable iff (sys_rst_i)
      general_trip_out_o |-> internal_trip_o;
  endproperty
  a_gen_follows: assert property (p_gen_follows)
    else $error("general without internal");

  property p_range;
    @(posedge clock_i) disable iff (sys_rst_i)
      start_pct_o >= MIN_PCT && start_pct_o <= rioc_pkg::START_PCT_MAX_EXT;
  endproperty
  a_range: assert property (p_range) else $error("setting out of range");

  property p_reject;
    @(posedge clock_i) disable iff (sys_rst_i)
      start_pct_load_i && !pct_ok(start_pct_i, ext_range_i) |=> $stable(start_pct_o);
  endproperty
  a_reject: assert property (p_reject) else $error("bad setting taken");

  property p_load;
    @(posedge clock_i) disable iff (sys_rst_i)
      start_pct_load_i && pct_ok(start_pct_i, ext_range_i) |=> start_pct_o == $past(start_pct_i);
  endproperty
  a_load: assert property (p_load) else $error("setting not taken");

  // Reference figures for the checks, worked from the ports apart from the compare path
  logic [31:0] ref_cur_x100;
  logic [31:0] ref_thr_x100;
  assign ref_cur_x100 = 32'((mode_i == rioc_pkg::RIOC_MODE_PEAK) ? meas_i.peak : meas_i.fund)
                        * 32'(rioc_pkg::PCT_DIV);
  assign ref_thr_x100 = 32'(rated_current_i) * 32'(start_pct_o)
                        * (threshold_double_in_i ? 32'h2 : 32'h1);

  // At or below twice the setting a doubled strobe never trips
  property p_double;
    @(posedge clock_i) disable iff (sys_rst_i)
      meas_i.valid && threshold_double_in_i && mode_i != rioc_pkg::RIOC_MODE_OFF
      && ref_cur_x100 <= ref_thr_x100
      |=> !internal_trip_o;
  endproperty
  a_double: assert property (p_double) else $error("doubled threshold ignored");

  // A strobe above the effective threshold trips on the next edge
  property p_pickup;
    @(posedge clock_i) disable iff (sys_rst_i)
      meas_i.valid && (mode_i == rioc_pkg::RIOC_MODE_PEAK || mode_i == rioc_pkg::RIOC_MODE_FUND)
      && ref_cur_x100 > ref_thr_x100
      |=> internal_trip_o;
  endproperty
  a_pickup: assert property (p_pickup) else $error("no trip above threshold");

  // Released disable lets a held internal trip through again
  property p_release;
    @(posedge clock_i) disable iff (sys_rst_i)
      internal_trip_o && !meas_i.valid && !function_disable_in_i
      && mode_i != rioc_pkg::RIOC_MODE_OFF |=> general_trip_out_o;
  endproperty
  a_release: assert property (p_release)
    else $error("general trip not restored");

  // Reset clears both trips and restores the default setting
  property p_reset_val;
    @(posedge clock_i)
      sys_rst_i |=> start_pct_o == rioc_pkg::START_PCT_RST
      && !internal_trip_o && !general_trip_out_o;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("reset values wrong");

  c_peak_trip: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    mode_i == rioc_pkg::RIOC_MODE_PEAK ##1 general_trip_out_o);
  c_fund_trip: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    mode_i == rioc_pkg::RIOC_MODE_FUND ##1 general_trip_out_o);
  c_blocked: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    internal_trip_o && !general_trip_out_o);
  c_reset_trip: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    internal_trip_o ##1 !internal_trip_o);
  c_double_trip: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    threshold_double_in_i && meas_i.valid ##1 internal_trip_o);
endmodule : rioc_core
`default_nettype wire

// *** logic/rioc_pkg.sv ***
// Package of constants and types for the residual instantaneous overcurrent core
`default_nettype none
package rioc_pkg;
  // ----------------------------------------------------------------------
  // Widths and setting limits
  // ----------------------------------------------------------------------
  localparam int unsigned CUR_W = 16;
  localparam int unsigned PCT_W = 12;
  localparam logic [11:0] START_PCT_RST = 12'h0c8;
  localparam logic [11:0] START_PCT_MIN = 12'h00a;
  localparam logic [11:0] START_PCT_MAX = 12'h3e8;
  localparam logic [11:0] START_PCT_MAX_EXT = 12'hbb8;
  localparam int unsigned PCT_DIV = 100;

  // Operation mode codes
  typedef enum logic [1:0] {
    RIOC_MODE_OFF = 2'h0,
    RIOC_MODE_PEAK = 2'h1,
    RIOC_MODE_FUND = 2'h2
  } rioc_mode_t;

  // Measurement strobe from the front end
  typedef struct packed {
    logic valid;
    logic [CUR_W-1:0] peak;
    logic [CUR_W-1:0] fund;
  } rioc_meas_t;

  // Whole state of the core
  typedef struct packed {
    logic internal_trip;
    logic general_trip;
    logic [PCT_W-1:0] start_pct;
  } rioc_state_t;
endpackage : rioc_pkg
`default_nettype wire

// *** testbench/residual_instant_overcurrent_trip_tb_top.sv ***
// Self-checking testbench of the residual overcurrent core
`default_nettype none
module residual_instant_overcurrent_trip_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, sys_rst_i, load, ext, dbl, dis, itrip, gtrip;
  rioc_pkg::rioc_mode_t mode;
  rioc_pkg::rioc_meas_t meas;
  logic [11:0] pct, spct;
  logic [15:0] rated;
  int errors, cmp_count;
  logic [11:0] lv [6] = '{12'h009, 12'h3e9, 12'h00a, 12'hbb8, 12'hbb9, 12'h3e8};
  logic [11:0] le [6] = '{12'h0c8, 12'h0c8, 12'h00a, 12'hbb8, 12'hbb8, 12'h3e8};
  logic lx [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  // Clock of 8 ns period
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  rioc_fe_model i_fe (.clock_i(clock_i), .meas_o(meas));
  rioc_core #(.MIN_PCT(12'h00a)) i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .meas_i(meas), .mode_i(mode), .start_pct_i(pct), .start_pct_load_i(load),
    .ext_range_i(ext), .threshold_double_in_i(dbl), .function_disable_in_i(dis),
    .rated_current_i(rated), .internal_trip_o(itrip), .general_trip_out_o(gtrip),
    .start_pct_o(spct));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic trips(input string nm, input logic it, input logic gt);
    chk({nm, " internal"}, {15'h0, it}, {15'h0, itrip});
    chk({nm, " general"}, {15'h0, gt}, {15'h0, gtrip});
  endtask : trips
  task automatic load_pct(input logic [11:0] v);
    @(negedge clock_i);
    pct = v;
    load = 1'b1;
    @(negedge clock_i);
    load = 1'b0;
  endtask : load_pct
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk("start_pct", 16'h00c8, {4'h0, spct});
    i_fe.send(16'hffff, 16'hffff);
    trips("mode off", 1'b0, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_select();
    mode = rioc_pkg::RIOC_MODE_PEAK;
    i_fe.send(16'h00c9, 16'h0000);
    trips("peak above", 1'b1, 1'b1);
    i_fe.send(16'h00c8, 16'hffff);
    trips("peak equal", 1'b0, 1'b0);
    mode = rioc_pkg::RIOC_MODE_FUND;
    i_fe.send(16'hffff, 16'h00c8);
    trips("fund equal", 1'b0, 1'b0);
    i_fe.send(16'h0000, 16'h00c9);
    trips("fund above", 1'b1, 1'b1);
    $display("t_select done");
  endtask : t_select
  task automatic t_double();
    dbl = 1'b1;
    i_fe.send(16'h0000, 16'h0190);
    trips("double equal", 1'b0, 1'b0);
    i_fe.send(16'h0000, 16'h0191);
    trips("double above", 1'b1, 1'b1);
    dbl = 1'b0;
    dis = 1'b1;
    i_fe.send(16'h0000, 16'h01f4);
    trips("disabled", 1'b1, 1'b0);
    dis = 1'b0;
    @(negedge clock_i);
    trips("released", 1'b1, 1'b1);
    mode = rioc_pkg::RIOC_MODE_OFF;
    @(negedge clock_i);
    trips("switched off", 1'b0, 1'b0);
    $display("t_double done");
  endtask : t_double
  task automatic t_limits();
    for (int i = 0; i < 6; i++) begin
      ext = lx[i];
      load_pct(lv[i]);
      chk("start_pct", {4'h0, le[i]}, {4'h0, spct});
    end
    $display("t_limits done");
  endtask : t_limits
  // Mid-run reset, then threshold scaled by a different rated current
  task automatic t_rerun();
    mode = rioc_pkg::RIOC_MODE_PEAK;
    i_fe.send(16'hffff, 16'h0000);
    trips("before reset", 1'b1, 1'b1);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    sys_rst_i = 1'b0;
    chk("start_pct again", 16'h00c8, {4'h0, spct});
    trips("after reset", 1'b0, 1'b0);
    rated = 16'h0032;
    i_fe.send(16'h0064, 16'hffff);
    trips("half rated equal", 1'b0, 1'b0);
    i_fe.send(16'h0065, 16'h0000);
    trips("half rated above", 1'b1, 1'b1);
    mode = rioc_pkg::RIOC_MODE_OFF;
    @(negedge clock_i);
    trips("off again", 1'b0, 1'b0);
    $display("t_rerun done");
  endtask : t_rerun
  // Main sequence
  initial begin
    {load, ext, dbl, dis, errors, cmp_count} = '0;
    pct = 12'h0c8;
    rated = 16'h0064;
    mode = rioc_pkg::RIOC_MODE_OFF;
    sys_rst_i = 1'b1;
    repeat (12) @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_select();
    t_double();
    t_limits();
    t_rerun();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #20us;
    errors++;
    final_report();
  end
endmodule : residual_instant_overcurrent_trip_tb_top
`default_nettype wire

// *** testbench/rioc_fe_model.sv ***
// Behavioural measurement front end feeding strobes to the core
`default_nettype none
module rioc_fe_model (
  input wire logic clock_i,
  output var rioc_pkg::rioc_meas_t meas_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle strobe, stale values inverted afterwards
  task automatic send(input logic [15:0] pk, input logic [15:0] fu);
    @(negedge clock_i);
    meas_o = '{valid: 1'b1, peak: pk, fund: fu};
    @(negedge clock_i);
    meas_o = '{valid: 1'b0, peak: ~pk, fund: ~fu};
  endtask : send
  // Idle at time zero
  initial meas_o = '0;
endmodule : rioc_fe_model
`default_nettype wire
